// >>> core/ddr3_cal_pkg.sv
// Shared constants and types for the calibration/read/bank command block
package ddr3_cal_pkg;
	// ********************
	// Register map
	// ********************
	localparam logic [11:0] CTRL_OFFS = 12'h000;
	localparam logic [11:0] STAT_OFFS = 12'h004;
	localparam int AL_LSB = 0;
	localparam int CL_LSB = 4;
	localparam int DLL_BIT = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0160;
	localparam int ST_CAL_BIT = 0;
	localparam int ST_BL_LSB = 1;
	localparam int ST_BURST_BIT = 3;
	localparam int ST_OPEN_LSB = 8;
	localparam int ST_PRE_LSB = 16;
	// ********************
	// Command pins and fields
	// ********************
	localparam logic [2:0] CMD_MODE = 3'h0;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CAL_REG_BANK = 3'h3;
	localparam logic [2:0] BURST_REG_BANK = 3'h0;
	localparam int CAL_EN_BIT = 2;
	localparam int AUTOCLOSE_BIT = 10;
	localparam int CHOP_BIT = 12;
	localparam int NIBBLE_BIT = 2;
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam logic [1:0] BL_RST = 2'h0;
	// ********************
	// Timing
	// ********************
	localparam int CLK_MHZ = 125;
	localparam int PRE_NS = 15;
	localparam int PRE_CYC = (PRE_NS * CLK_MHZ + 999) / 1000;
	typedef struct packed {
		logic        cs_n;
		logic [2:0]  cmd;
		logic [2:0]  bank;
		logic [14:0] addr;
	} pins_t;
	typedef struct packed {
		logic       valid;
		logic       chop4;
		logic       nibble;
		logic       pattern;
		logic [2:0] col;
	} rd_t;
endpackage

// >>> core/ddr3_cal_dev.sv
// Device-side command decoder: calibration pattern reads, bank state, read bursts
// Function
// - Mode-set to calibration register with bit 2 set enables pattern reads.
// - Pattern reads ignore bank lines, autoclose line and unused address bits.
// - Burst starts total read delay, added plus column latency, after read.
// - Pattern data alternates 0,1 on successive beats.
// - Chopped pattern read: column bit 2 picks lower or upper nibble.
// - In pattern mode a read with autoclose acts as a plain read.
// - Mode-set with bit 2 clear returns reads to the memory array.
// - Activate opens the row given by address lines in the selected bank, outside pattern mode only.
// - Precharge closes one or all banks; reuse after the precharge period.
// - Precharge to idle or precharging bank is taken and restarts the period.
// - Chop select low gives four beats, high eight, in on-the-fly mode.
// - Chop select controls burst length only, never a column bit.
// - Length field 00 fixes eight beats; 01 selects on the fly.
// - Length field 10 fixes four-beat chopped bursts.
// - Strobe and data are driven only while the delay-locked loop is locked.
`timescale 1ns/1ps
module ddr3_cal_dev
	import ddr3_cal_pkg::*;
#(
	parameter int BANKS = 8,
	parameter int DEPTH = 32
) (
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        link_clk_i,
	input  wire pins_t       pins_i,
	output logic [15:0]      dq_o,
	output logic             dq_oe_o,
	output logic             dqs_o,
	output logic             dqs_oe_o
);
	// ********************
	// Reset and pin synchronisers
	// ********************
	logic       rst_s1_q, rst_n;
	logic [2:0] ck_s_q;
	logic       ck_st_q;
	pins_t      pin_s1_q, pin_s2_q, pin_s3_q;

	// Reset release through two flops
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	// Three-stage capture of the link clock and command pins
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ck_s_q <= 3'h0;
			ck_st_q <= 1'b0;
			pin_s1_q <= '1;
			pin_s2_q <= '1;
			pin_s3_q <= '1;
		end else begin
			ck_s_q <= {ck_s_q[1:0], link_clk_i};
			if (ck_s_q[1] == ck_s_q[2]) begin
				ck_st_q <= ck_s_q[2];
			end
			pin_s1_q <= pins_i;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Edge detection once second and third stages agree
	wire rise_w = ck_s_q[1] & ck_s_q[2] & ~ck_st_q;
	wire fall_w = ~ck_s_q[1] & ~ck_s_q[2] & ck_st_q;
	wire edge_w = rise_w | fall_w;

	// ********************
	// APB register slave
	// ********************
	logic [31:0] ctrl_q;
	logic        cal_q;
	logic [1:0]  bl_q;
	logic [BANKS-1:0] open_q;
	wire  [BANKS-1:0] pre_busy_w;
	logic        act_q;

	// Address decode, control fields and status word
	wire ctrl_hit_w = paddr_i == CTRL_OFFS;
	wire stat_hit_w = paddr_i == STAT_OFFS;
	wire setup_w = psel_i & ~penable_i;
	wire wr_w = psel_i & penable_i & pwrite_i & pready_o & ctrl_hit_w;
	wire [3:0] al_w = ctrl_q[AL_LSB +: 4];
	wire [3:0] cl_w = ctrl_q[CL_LSB +: 4];
	wire dll_w = ctrl_q[DLL_BIT];
	wire [31:0] stat_w = {8'h00, 8'(pre_busy_w), 8'(open_q), 4'h0, act_q, bl_q, cal_q};
	wire [31:0] rdsel_w = ctrl_hit_w ? ctrl_q : (stat_hit_w ? stat_w : 32'h0000_0000);

	// Answer in the cycle after setup; unmapped addresses get an error
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			ctrl_q <= CTRL_RST;
		end else begin
			pready_o <= setup_w;
			pslverr_o <= setup_w & ~ctrl_hit_w & ~stat_hit_w;
			prdata_o <= setup_w ? rdsel_w : 32'h0000_0000;
			if (wr_w) begin
				ctrl_q <= pwdata_i;
			end
		end
	end

	// ********************
	// Command decode
	// ********************
	// Command strobes, taken only at a detected rising link edge
	wire pins_t p_w = pin_s3_q;
	wire cmd_w = rise_w & ~p_w.cs_n;
	wire mode_w = cmd_w && p_w.cmd == CMD_MODE;
	wire act_cmd_w = cmd_w && p_w.cmd == CMD_ACT;
	wire pre_w = cmd_w && p_w.cmd == CMD_PRE;
	wire rd_w = cmd_w && p_w.cmd == CMD_RD;
	wire [4:0] rl_w = 5'(al_w) + 5'(cl_w);
	wire [4:0] rl_idx_w = (rl_w == 5'h00) ? 5'h00 : rl_w - 5'h01;
	// Length from the mode field, chop line only read in on-the-fly mode
	wire chop_w = (bl_q == BL_FIXED4) | ((bl_q == BL_OTF) & ~p_w.addr[CHOP_BIT]);
	// Column comes from A2:A0 only; chop line is never a column bit
	wire rd_t new_w = '{valid: 1'b1, chop4: chop_w, nibble: p_w.addr[NIBBLE_BIT],
		pattern: cal_q, col: p_w.addr[2:0]};

	// Mode-set to calibration and burst mode registers
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cal_q <= 1'b0;
			bl_q <= BL_RST;
		end else if (mode_w) begin
			if (p_w.bank == CAL_REG_BANK) begin
				cal_q <= p_w.addr[CAL_EN_BIT];
			end
			if (p_w.bank == BURST_REG_BANK) begin
				bl_q <= p_w.addr[1:0];
			end
		end
	end

	// ********************
	// Per-bank row and precharge state
	// ********************
	logic [14:0] row_q [BANKS];
	logic [3:0]  pre_cnt_q [BANKS];

	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		wire sel_w = p_w.bank == 3'(b);
		// Autoclose is ignored in pattern mode
		wire close_w = (pre_w & (p_w.addr[AUTOCLOSE_BIT] | sel_w))
			| (rd_w & ~cal_q & sel_w & p_w.addr[AUTOCLOSE_BIT]);
		assign pre_busy_w[b] = pre_cnt_q[b] != 4'h0;
		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				open_q[b] <= 1'b0;
				row_q[b] <= 15'h0000;
				pre_cnt_q[b] <= 4'h0;
			end else if (close_w) begin
				open_q[b] <= 1'b0;
				pre_cnt_q[b] <= 4'(PRE_CYC);
			end else if (act_cmd_w & sel_w & ~cal_q & ~pre_busy_w[b]) begin
				open_q[b] <= 1'b1;
				row_q[b] <= p_w.addr;
			end else if (pre_busy_w[b]) begin
				pre_cnt_q[b] <= pre_cnt_q[b] - 4'h1;
			end
		end
	end

	// ********************
	// Read latency line and burst output
	// ********************
	// Pending reads ordered by remaining latency, and the burst in flight
	rd_t pend_q [DEPTH];
	rd_t pend_nx_w [DEPTH];
	rd_t cur_q;
	logic [2:0] beat_q;

	// Each link rising edge moves pending reads one step closer
	for (genvar i = 0; i < DEPTH; i++) begin : g_pend
		rd_t next_w;
		if (i == DEPTH - 1) begin : g_top
			assign next_w = '0;
		end else begin : g_mid
			assign next_w = pend_q[i + 1];
		end
		assign pend_nx_w[i] = (rd_w && rl_idx_w == 5'(i)) ? new_w : next_w;
		always_ff @(posedge ref_clk_i or negedge rst_n) begin
			if (!rst_n) begin
				pend_q[i] <= '0;
			end else if (rise_w) begin
				pend_q[i] <= pend_nx_w[i];
			end
		end
	end

	// Burst start, last beat and beat data
	wire start_w = rise_w & pend_q[0].valid;
	wire last_w = act_q && beat_q == (cur_q.chop4 ? 3'h3 : 3'h7);
	// Burst order: nibble select forces bit 2 of the beat index high
	wire [2:0] idx_w = {beat_q[2] | cur_q.nibble, beat_q[1:0]};
	wire [15:0] data_w = cur_q.pattern ? {16{idx_w[0]}} : {13'h0000, idx_w ^ cur_q.col};

	// One beat per detected link edge
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			act_q <= 1'b0;
			cur_q <= '0;
			beat_q <= 3'h0;
		end else if (edge_w) begin
			if (start_w) begin
				act_q <= 1'b1;
				cur_q <= pend_q[0];
				beat_q <= 3'h0;
			end else if (last_w) begin
				act_q <= 1'b0;
			end else if (act_q) begin
				beat_q <= beat_q + 3'h1;
			end
		end
	end

	// Pin drivers; nothing driven unless the loop is locked
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dq_o <= 16'h0000;
			dq_oe_o <= 1'b0;
			dqs_o <= 1'b0;
			dqs_oe_o <= 1'b0;
		end else begin
			dq_o <= act_q ? data_w : 16'h0000;
			dq_oe_o <= act_q & dll_w;
			dqs_o <= act_q & ck_st_q;
			dqs_oe_o <= act_q & dll_w;
		end
	end

	// ********************
	// Assertions
	// ********************
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	// Mode-set, read queue, burst length and pattern data checks
	a_cal_mode_set: assert property (mode_w && p_w.bank == CAL_REG_BANK |=>
		cal_q == $past(p_w.addr[CAL_EN_BIT])) else $error("calibration mode not taken");
	a_read_queue: assert property (rd_w |=> pend_q[$past(rl_idx_w)].valid
		&& pend_q[$past(rl_idx_w)].pattern == $past(cal_q)) else $error("read not queued");
	a_chop_fixed: assert property (rd_w && bl_q == BL_FIXED4 |=>
		pend_q[$past(rl_idx_w)].chop4) else $error("fixed chop ignored");
	a_chop_otf: assert property (rd_w && bl_q == BL_OTF |=>
		pend_q[$past(rl_idx_w)].chop4 != $past(p_w.addr[CHOP_BIT])) else $error("chop select");
	a_pattern_alt: assert property (act_q && cur_q.pattern |=>
		dq_o == {16{$past(beat_q[0])}}) else $error("pattern beat wrong");
	// Burst, pin and bank checks
	a_burst_end: assert property (rise_w && last_w && !start_w |=> !act_q)
		else $error("burst overran");
	a_burst_start: assert property (start_w |=> act_q && beat_q == 3'h0
		&& cur_q == $past(pend_q[0])) else $error("burst not started");
	a_autoclose_ign: assert property (rd_w && cal_q |=> open_q == $past(open_q))
		else $error("bank closed in pattern mode");
	a_pre_all: assert property (pre_w && p_w.addr[AUTOCLOSE_BIT] |=> open_q == '0
		&& pre_busy_w == '1) else $error("precharge all failed");
	a_dll_gate: assert property (!dll_w |=> !dqs_oe_o && !dq_oe_o) else $error("drive unlocked");
	a_pre_bank: assert property (pre_w && !p_w.addr[AUTOCLOSE_BIT] |=>
		!open_q[$past(p_w.bank)] && pre_busy_w[$past(p_w.bank)]) else $error("bank not closed");
	a_act_open: assert property (act_cmd_w && !cal_q && !pre_busy_w[p_w.bank] |=>
		open_q[$past(p_w.bank)] && row_q[$past(p_w.bank)] == $past(p_w.addr))
		else $error("row not opened");
	a_rd_autoclose: assert property (rd_w && !cal_q && p_w.addr[AUTOCLOSE_BIT] |=>
		!open_q[$past(p_w.bank)]) else $error("autoclose ignored");

	c_pattern_read: cover property (start_w && pend_q[0].pattern && !pend_q[0].chop4);
	c_chop_upper: cover property (start_w && pend_q[0].chop4 && pend_q[0].nibble);
	c_back_to_back: cover property (last_w && start_w);
	c_apb_error: cover property (pslverr_o && pready_o);
endmodule

// >>> test/ddr3_ctrl_model.sv
// Controller-side model: free-running link clock and single command launches
`timescale 1ns/1ps
module ddr3_ctrl_model
	import ddr3_cal_pkg::*;
(
	input  wire logic  go_i,
	input  wire pins_t cmd_i,
	output logic       link_clk_o,
	output pins_t      pins_o,
	output logic       done_o
);
	// Link clock, 160 ns period
	initial begin
		link_clk_o = 1'b0;
		forever #80 link_clk_o = ~link_clk_o;
	end
	// Launch on falling edge, held through the taking rising edge, then deselect
	initial begin
		pins_o = '1;
		done_o = 1'b0;
		forever begin
			@(negedge link_clk_o);
			if (go_i) begin
				pins_o = cmd_i;
				@(posedge link_clk_o);
				done_o = 1'b1;
				@(negedge link_clk_o);
				done_o = 1'b0;
				pins_o.cs_n = 1'b1;
				pins_o.addr = ~pins_o.addr; // Released lines do not keep the last value
			end
		end
	end
endmodule

// >>> test/ddr3_calibration_read_bank_cmds_tb.sv
// Testbench: register access, calibration pattern reads, bank commands, read bursts
`timescale 1ns/1ps
module ddr3_calibration_read_bank_cmds_tb;
	import ddr3_cal_pkg::*;
	localparam int AL_V = 2;
	localparam int CL_V = 6;
	localparam int EXIT_GAP = 16; // Gap after each read burst in reference cycles, a free choice
	logic        ref_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic        link_clk, go, done, dq_oe_o, dqs_o, dqs_oe_o, dqs_q, oe_q;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rdat;
	logic [15:0] dq_o;
	logic [14:0] ra;
	pins_t       pins, cmd;
	int          errors, comparisons, exp_rl, n, seed;
	time         t_cmd;
	logic [15:0] exp_q[$];
	ddr3_cal_dev dut (.ref_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link_clk_i(link_clk), .pins_i(pins),
		.dq_o, .dq_oe_o, .dqs_o, .dqs_oe_o);
	ddr3_ctrl_model ctrl (.go_i(go), .cmd_i(cmd), .link_clk_o(link_clk), .pins_o(pins),
		.done_o(done));
	// Reference clock, 8 ns
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic flag(input int s);
		return s == 0 ? pready_o : s == 1 ? done : s == 2 ? dq_oe_o : exp_q.size() == 0;
	endfunction
	// Bounded wait on reference edges for a flag level
	task automatic wait_for(input int s, input logic v);
		n = 0;
		while (flag(s) !== v && n < 400) begin
			@(posedge ref_clk_i);
			n++;
		end
		if (n >= 400) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		@(posedge ref_clk_i);
		wait_for(0, 1'b1);
		rdat = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [14:0] a);
		@(posedge ref_clk_i);
		cmd <= '{1'b0, c, b, a};
		go <= 1'b1;
		@(posedge ref_clk_i);
		wait_for(1, 1'b1);
		t_cmd = $time;
		go <= 1'b0;
		wait_for(1, 1'b0);
		repeat (160) @(posedge ref_clk_i);
	endtask
	task automatic rd(input logic [2:0] b, input logic [14:0] a, input int beats,
		input logic pat);
		for (int i = 0; i < beats; i++) begin
			exp_q.push_back(pat ? {16{i[0]}} : {13'h0, 3'(i) ^ a[2:0]});
		end
		issue(CMD_RD, b, a);
		wait_for(3, 1'b1);
		wait_for(2, 1'b0);
		repeat (EXIT_GAP) @(posedge ref_clk_i);
	endtask
	// Takes each beat off the queue as the strobe marks it
	always @(posedge ref_clk_i) begin
		dqs_q <= dqs_o;
		oe_q <= dq_oe_o;
		if (dq_oe_o === 1'b1 && (oe_q !== 1'b1 || dqs_o !== dqs_q)) begin
			if (oe_q !== 1'b1) begin
				check(32'(($time - t_cmd) / 160), exp_rl);
				check({31'h0, dqs_oe_o & dqs_o}, 32'h1);
			end
			if (exp_q.size() > 0) begin
				check({16'h0, dq_o}, {16'h0, exp_q.pop_front()});
			end else begin
				check(32'h0, 32'h1);
			end
		end
	end
	// Reset, then register, pattern and bank scenarios
	initial begin
		seed = 32'h6f7b;
		{nrst_i, psel_i, penable_i, pwrite_i, go} = '0;
		paddr_i = '0;
		pwdata_i = '0;
		cmd = '1;
		errors = 0;
		comparisons = 0;
		exp_rl = AL_V + CL_V;
		t_cmd = 0;
		repeat (2) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		apb(1'b0, CTRL_OFFS, 32'h0);
		check(rdat, CTRL_RST);
		apb(1'b1, STAT_OFFS, 32'hFFFF_FFFF);
		apb(1'b0, STAT_OFFS, 32'h0);
		check(rdat, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		check({rdat[30:0], err}, 32'h1);
		apb(1'b1, CTRL_OFFS, (1 << DLL_BIT) | (CL_V << CL_LSB) | (AL_V << AL_LSB));
		apb(1'b0, CTRL_OFFS, 32'h0);
		check(rdat, 32'h0000_0162);
		$display("register test done");
		issue(CMD_PRE, 3'h0, 15'h0400);
		issue(CMD_MODE, BURST_REG_BANK, {13'h0, BL_OTF});
		issue(CMD_MODE, CAL_REG_BANK, 15'h0004);
		apb(1'b0, STAT_OFFS, 32'h0);
		check({31'h0, rdat[ST_CAL_BIT]}, 32'h1);
		for (int k = 0; k < 2; k++) begin
			ra = 15'($random(seed));
			rd(3'($random(seed)), {ra[14:13], 1'b1, ra[11:3], 3'h0}, 8, 1'b1);
		end
		rd(3'h0, 15'h0004, 4, 1'b1);
		rd(3'h0, 15'h0000, 4, 1'b1);
		$display("pattern test done");
		issue(CMD_MODE, CAL_REG_BANK, 15'h0000);
		apb(1'b0, STAT_OFFS, 32'h0);
		check(rdat, 32'(BL_OTF) << ST_BL_LSB);
		issue(CMD_MODE, BURST_REG_BANK, {13'h0, BL_FIXED4});
		issue(CMD_ACT, 3'h5, 15'($random(seed)));
		apb(1'b0, STAT_OFFS, 32'h0);
		check(rdat, (32'h1 << (ST_OPEN_LSB + 5)) | (32'(BL_FIXED4) << ST_BL_LSB));
		rd(3'h5, 15'h1003, 4, 1'b0);
		issue(CMD_PRE, 3'h5, 15'h0000);
		issue(CMD_PRE, 3'h5, 15'h0000);
		apb(1'b0, STAT_OFFS, 32'h0);
		check(rdat, 32'(BL_FIXED4) << ST_BL_LSB);
		issue(CMD_MODE, BURST_REG_BANK, {13'h0, BL_FIXED8});
		issue(CMD_ACT, 3'h5, 15'($random(seed)));
		issue(CMD_ACT, 3'h2, 15'($random(seed)));
		rd(3'h5, 15'h0403, 8, 1'b0);
		rd(3'h2, 15'h0001, 8, 1'b0);
		apb(1'b0, STAT_OFFS, 32'h0);
		check(rdat, 32'h1 << (ST_OPEN_LSB + 2));
		apb(1'b1, CTRL_OFFS, (CL_V << CL_LSB) | (AL_V << AL_LSB));
		issue(CMD_RD, 3'h2, 15'h1000);
		apb(1'b0, STAT_OFFS, 32'h0);
		check(rdat, (32'h1 << (ST_OPEN_LSB + 2)) | (32'h1 << ST_BURST_BIT));
		check({31'h0, dq_oe_o | dqs_oe_o}, 32'h0);
		repeat (100) @(posedge ref_clk_i);
		$display("bank test done");
		end_of_test();
	end
endmodule
